// ===== rtl/spf_pkg.sv
// Constants, encodings and carriers for the flash self-programming block.
// Assumes one 10 MHz clock and a 32-bit AHB-Lite register bus.
package spf_pkg;

	// ==================================================================
	// Register map and control fields
	localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam int          BIT_SIG     = 5;
	localparam int          BIT_CLEAR_PAGE_BUFFER    = 4;
	localparam int          BIT_FLR     = 3;
	localparam int          BIT_PGW     = 2;
	localparam int          BIT_PGE     = 1;
	localparam int          BIT_EN      = 0;

	// ==================================================================
	// Accepted six-bit command patterns
	localparam logic [5:0] CMD_SIG  = 6'h21;
	localparam logic [5:0] CMD_CLEAR_PAGE_BUFFER = 6'h11;
	localparam logic [5:0] CMD_FLR  = 6'h09;
	localparam logic [5:0] CMD_PGW  = 6'h05;
	localparam logic [5:0] CMD_PGE  = 6'h03;
	localparam logic [5:0] CMD_LOAD = 6'h01;

	// ==================================================================
	// Timing
	localparam logic [2:0] SPM_WINDOW   = 3'h4;
	localparam logic [2:0] LPM_WINDOW   = 3'h3;
	localparam int         CLK_MHZ      = 10;
	localparam int         FLASH_MIN_US = 3700;
	localparam int         FLASH_MAX_US = 4500;
	// Band's lower edge in cycles
	localparam int FLASH_CYC = FLASH_MIN_US * CLK_MHZ;

	// ==================================================================
	// Flash geometry and pointer fields
	localparam int PAGE_WORDS = 64;
	localparam int WIDX_W     = 6;
	localparam int PAGE_W     = 9;
	localparam int WIDX_LSB   = 1;
	localparam int PAGE_LSB   = 7;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	// ==================================================================
	// Fuse and signature addresses
	localparam logic [1:0] Z_FUSE_LOW  = 2'h0;
	localparam logic [1:0] Z_LOCK      = 2'h1;
	localparam logic [1:0] Z_FUSE_EXT  = 2'h2;
	localparam logic [1:0] Z_FUSE_HIGH = 2'h3;
	localparam logic [5:0] LOCK_UNUSED = 6'h3F;
	localparam logic [6:0] EXT_UNUSED  = 7'h7F;
	// Identification bytes: arbitrary neutral values
	localparam logic [7:0] SIG_ID0 = 8'h5A;
	localparam logic [7:0] SIG_ID1 = 8'h01;
	localparam logic [7:0] SIG_ID2 = 8'h02;
	localparam logic [7:0] SIG_RSVD = 8'hFF;

	// ==================================================================
	// Types
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_FLASH = 2'b11
	} spf_state_t;

	typedef struct packed {
		logic        spm;
		logic        lpm;
		logic [15:0] z;
		logic [15:0] data_word_pair;
	} spf_cpu_req_t;

	typedef struct packed {
		logic [7:0] fuse_low_byte;
		logic [7:0] fuse_high_byte;
		logic       fuse_extended_byte;
		logic       lock_bit_high;
		logic       lock_bit_low;
	} spf_fuse_t;

endpackage : spf_pkg

// ===== rtl/spf_page_buf.sv
// Temporary page buffer held in flip-flops.
// Assumes the controller gives it one write or clear per cycle.
`timescale 1ns/1ns
module spf_page_buf (
	// Clock and reset
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	// Fill side
	input  wire logic                      clr,
	input  wire logic                      wr_en,
	input  wire logic [spf_pkg::WIDX_W-1:0] wr_idx,
	input  wire logic [15:0]               wr_data,
	// Drain side, read by the flash array
	input  wire logic [spf_pkg::WIDX_W-1:0] rd_idx,
	output logic      [15:0]               rd_data
);

	// ==================================================================
	// Storage
	logic [15:0] mem_ff [spf_pkg::PAGE_WORDS];
	logic [spf_pkg::PAGE_WORDS-1:0] used_ff;

	// Words may be loaded once until the buffer is cleared
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			used_ff <= '0;
		end else if (clr) begin
			used_ff <= '0;
		end else if (wr_en) begin
			used_ff[wr_idx] <= 1'b1;
		end
	end

	// Data flops; a clear restores the erased pattern
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < spf_pkg::PAGE_WORDS; i++) begin
				mem_ff[i] <= spf_pkg::ERASED_WORD;
			end
		end else if (clr) begin
			for (int i = 0; i < spf_pkg::PAGE_WORDS; i++) begin
				mem_ff[i] <= spf_pkg::ERASED_WORD;
			end
		end else if (wr_en && !used_ff[wr_idx]) begin
			mem_ff[wr_idx] <= wr_data;
		end
	end

	// Indexed read
	assign rd_data = mem_ff[rd_idx];

endmodule : spf_page_buf

// ===== rtl/spf_ctrl.sv
// Flash self-programming controller: control register, command
// windows, fuse/lock/signature reads and timed erase/write.
// Assumes an AHB-Lite master with one slave, and a CPU core that
// raises spm or lpm for one cycle per instruction and obeys stall.
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns

// What this block does
// - Signature select and enable: LPM within three cycles reads sig byte.
// - Signature select plus enable: SPM within four cycles does nothing.
// - Writing clear-buffer command empties the temporary page buffer.
// - Fuse/lock select and enable: LPM in three cycles reads fuse or lock.
// - Page-write command: SPM within four cycles programs the buffer.
// - Page-erase command: SPM within four cycles erases the page.
// - Write and erase selects clear at completion or on window timeout.
// - CPU stalls for the whole erase or write.
// - Enable alone: SPM stores the data pair at the pointer word.
// - Enable lasts four cycles, clears after the SPM or timeout.
// - Enable stays set through erase and write as busy flag.
// - Only six control patterns act; all others are ignored.
// - EEPROM write busy blocks programming and fuse/lock reads.
// - Pointer 1 returns both lock bits in bits 1 and 0.
// - Fuse/lock select clears after read, three-cycle or SPM window.
// - Pointer 0 returns the low fuse byte.
// - Pointer 3 returns high fuse, pointer 2 extended fuse bit 0.
// - Programmed fuse and lock bits read zero, unprogrammed one.
// - Signature select clears after the read or three idle cycles.
// - Signature row: ids at 0,2,4; calibration and sensor at 1,3,5.
// - Erase and write last between 3.7 and 4.5 ms.
// - Control bit 7 reserved and bit 6 busy flag read zero.
module spf_ctrl #(
	parameter int FLASH_CYCLES = spf_pkg::FLASH_CYC
) (
	// Clock and reset
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	// AHB-Lite slave
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic                            hresp,
	output logic      [31:0]                hrdata,
	// CPU instruction side
	input  wire spf_pkg::spf_cpu_req_t      cpu_req,
	output logic                            cpu_stall,
	output logic                            lpm_valid,
	output logic      [7:0]                 lpm_data,
	// EEPROM status
	input  wire logic                       eeprom_write_busy,
	// Non-volatile values
	input  wire spf_pkg::spf_fuse_t         fuses,
	input  wire logic [7:0]                 osc_cal_byte,
	input  wire logic [7:0]                 temp_sensor_offset,
	input  wire logic [7:0]                 temp_sensor_gain,
	// Flash array
	output logic                            flash_erase,
	output logic                            flash_program,
	output logic      [spf_pkg::PAGE_W-1:0] flash_page,
	input  wire logic [spf_pkg::WIDX_W-1:0] flash_rd_idx,
	output logic      [15:0]                flash_rd_word
);

	// ==================================================================
	// Functions

	// Command pattern accepted by the control register
	function automatic logic legal_cmd(input logic [5:0] c);
		legal_cmd = (c == spf_pkg::CMD_SIG)  ||
		            (c == spf_pkg::CMD_CLEAR_PAGE_BUFFER) ||
		            (c == spf_pkg::CMD_FLR)  ||
		            (c == spf_pkg::CMD_PGW)  ||
		            (c == spf_pkg::CMD_PGE)  ||
		            (c == spf_pkg::CMD_LOAD);
	endfunction : legal_cmd

	// Fuse or lock byte by pointer, 0 = programmed
	function automatic logic [7:0] fuse_byte(
		input logic [1:0]         za,
		input spf_pkg::spf_fuse_t f
	);
		case (za)
			spf_pkg::Z_FUSE_LOW:  fuse_byte = f.fuse_low_byte;
			spf_pkg::Z_LOCK:      fuse_byte = {spf_pkg::LOCK_UNUSED,
			                       f.lock_bit_high,
			                       f.lock_bit_low};
			spf_pkg::Z_FUSE_EXT:  fuse_byte = {spf_pkg::EXT_UNUSED,
			                       f.fuse_extended_byte};
			spf_pkg::Z_FUSE_HIGH: fuse_byte = f.fuse_high_byte;
			default:              fuse_byte = f.fuse_low_byte;
		endcase
	endfunction : fuse_byte

	// ==================================================================
	// Declarations
	spf_pkg::spf_state_t        state_ff;
	spf_pkg::spf_state_t        nxt_state;
	logic [5:0]                 ctrl_ff;
	logic [5:0]                 nxt_ctrl;
	logic [2:0]                 win_ff;
	logic [2:0]                 nxt_win;
	logic [15:0]                op_cnt_ff;
	logic                       op_write_ff;
	logic [spf_pkg::PAGE_W-1:0] page_ff;
	logic                       bus_wr_ff;
	logic                       bus_rd_ff;
	logic                       bus_hit_ff;
	logic                       addr_phase;
	logic                       ctrl_wr;
	logic                       read_cmd;
	logic [2:0]                 win_len;
	logic                       win_open;
	logic                       spm_ok;
	logic                       lpm_ok;
	logic                       op_start;
	logic                       op_done;
	logic                       buf_clr;
	logic                       buf_wr;
	logic [7:0]                 sig_byte;

	// ==================================================================
	// AHB-Lite slave

	// Never waits and never errors
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addr_phase = hsel && htrans[1] && hready;

	// Address phase captured for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_wr_ff  <= 1'b0;
			bus_rd_ff  <= 1'b0;
			bus_hit_ff <= 1'b0;
		end else if (hready) begin
			bus_wr_ff  <= addr_phase && hwrite;
			bus_rd_ff  <= addr_phase && !hwrite;
			bus_hit_ff <= (haddr == spf_pkg::CTRL_OFFSET) &&
			              (hsize == 3'h2);
		end
	end

	// Upper two bits always read zero; unmapped reads zero
	assign hrdata = (bus_rd_ff && bus_hit_ff) ?
	                {24'h0000_00, 2'b00, ctrl_ff} :
	                32'h0000_0000;

	// Busy operation and EEPROM writes lock the register out
	assign ctrl_wr = bus_wr_ff && bus_hit_ff &&
	                 legal_cmd(hwdata[5:0]) &&
	                 !eeprom_write_busy &&
	                 (state_ff != spf_pkg::ST_FLASH);

	// ==================================================================
	// Command windows

	// Read commands live for three cycles, the rest for four
	assign read_cmd = ctrl_ff[spf_pkg::BIT_SIG] ||
	                  ctrl_ff[spf_pkg::BIT_FLR];
	assign win_len  = read_cmd ? spf_pkg::LPM_WINDOW :
	                             spf_pkg::SPM_WINDOW;
	assign win_open = (state_ff == spf_pkg::ST_ARMED);

	// SPM limit is four cycles, but a fuse read window closes after three
	assign spm_ok = win_open && cpu_req.spm &&
	                (win_ff < spf_pkg::SPM_WINDOW) &&
	                !eeprom_write_busy;
	assign lpm_ok = win_open && cpu_req.lpm && read_cmd &&
	                (win_ff < spf_pkg::LPM_WINDOW) &&
	                !eeprom_write_busy;

	// Erase and write start only from their own pattern
	assign op_start = spm_ok &&
	                  ((ctrl_ff == spf_pkg::CMD_PGW) ||
	                   (ctrl_ff == spf_pkg::CMD_PGE));
	assign op_done  = (state_ff == spf_pkg::ST_FLASH) &&
	                  (op_cnt_ff == 16'(FLASH_CYCLES - 1));

	// Next state and control bits
	always_comb begin
		nxt_state = state_ff;
		nxt_ctrl  = ctrl_ff;
		nxt_win   = win_ff;
		case (state_ff)
			spf_pkg::ST_IDLE: begin
				if (ctrl_wr) begin
					nxt_state = spf_pkg::ST_ARMED;
					nxt_ctrl  = hwdata[5:0];
					nxt_win   = 3'h0;
				end
			end
			spf_pkg::ST_ARMED: begin
				nxt_win = win_ff + 3'h1;
				if (op_start) begin
					// Enable held high as busy
					nxt_state = spf_pkg::ST_FLASH;
				end else if (lpm_ok) begin
					// Completed sig or fuse read
					nxt_state = spf_pkg::ST_IDLE;
					nxt_ctrl  = 6'h00;
				end else if (spm_ok &&
				             ctrl_ff != spf_pkg::CMD_SIG) begin
					// Load, clear or fuse-read SPM ends
					nxt_state = spf_pkg::ST_IDLE;
					nxt_ctrl  = 6'h00;
				end else if (ctrl_wr) begin
					// Rewrite restarts the window
					nxt_ctrl = hwdata[5:0];
					nxt_win  = 3'h0;
				end else if (win_ff >= win_len - 3'h1) begin
					// Window ran out unused
					nxt_state = spf_pkg::ST_IDLE;
					nxt_ctrl  = 6'h00;
				end
			end
			spf_pkg::ST_FLASH: begin
				if (op_done) begin
					// Select and enable drop together
					nxt_state = spf_pkg::ST_IDLE;
					nxt_ctrl  = 6'h00;
				end
			end
			default: begin
				nxt_state = spf_pkg::ST_IDLE;
				nxt_ctrl  = 6'h00;
			end
		endcase
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= spf_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Control bits and window age
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= spf_pkg::CTRL_RESET[5:0];
			win_ff  <= 3'h0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			win_ff  <= nxt_win;
		end
	end

	// ==================================================================
	// Timed erase and write

	// Cycle count fixed at the band's lower edge from the 10 MHz clock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_cnt_ff <= 16'h0000;
		end else if (op_start) begin
			op_cnt_ff <= 16'h0000;
		end else if (state_ff == spf_pkg::ST_FLASH) begin
			op_cnt_ff <= op_cnt_ff + 16'h0001;
		end
	end

	// Page comes from the pointer's upper bits; data pair unused
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			page_ff     <= '0;
			op_write_ff <= 1'b0;
		end else if (op_start) begin
			page_ff     <= cpu_req.z[15:spf_pkg::PAGE_LSB];
			op_write_ff <= ctrl_ff[spf_pkg::BIT_PGW];
		end
	end

	// Core is held from the starting SPM until the last cycle
	assign cpu_stall = op_start ||
	                   (state_ff == spf_pkg::ST_FLASH);
	assign flash_erase   = (state_ff == spf_pkg::ST_FLASH) &&
	                       !op_write_ff;
	assign flash_program = (state_ff == spf_pkg::ST_FLASH) &&
	                       op_write_ff;
	assign flash_page    = page_ff;

	// ==================================================================
	// Temporary page buffer

	// Clear on the clear command write, its SPM, or after a write
	assign buf_clr = (ctrl_wr &&
	                  hwdata[5:0] == spf_pkg::CMD_CLEAR_PAGE_BUFFER) ||
	                 (spm_ok && ctrl_ff == spf_pkg::CMD_CLEAR_PAGE_BUFFER) ||
	                 (op_done && op_write_ff);
	// Pointer bit 0 is dropped to address words
	assign buf_wr  = spm_ok && ctrl_ff == spf_pkg::CMD_LOAD;

	spf_page_buf u_buf (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clr     (buf_clr),
		.wr_en   (buf_wr),
		.wr_idx  (cpu_req.z[spf_pkg::PAGE_LSB-1:spf_pkg::WIDX_LSB]),
		.wr_data (cpu_req.data_word_pair),
		.rd_idx  (flash_rd_idx),
		.rd_data (flash_rd_word)
	);

	// ==================================================================
	// Load-program answers

	// Signature row by pointer; unlisted addresses read as reserved
	always_comb begin
		case (cpu_req.z)
			16'h0000: sig_byte = spf_pkg::SIG_ID0;
			16'h0001: sig_byte = osc_cal_byte;
			16'h0002: sig_byte = spf_pkg::SIG_ID1;
			16'h0003: sig_byte = temp_sensor_offset;
			16'h0004: sig_byte = spf_pkg::SIG_ID2;
			16'h0005: sig_byte = temp_sensor_gain;
			default:  sig_byte = spf_pkg::SIG_RSVD;
		endcase
	end

	// Answer stands one cycle after the LPM
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lpm_valid <= 1'b0;
			lpm_data  <= 8'h00;
		end else begin
			lpm_valid <= lpm_ok;
			if (lpm_ok && ctrl_ff[spf_pkg::BIT_SIG]) begin
				lpm_data <= sig_byte;
			end else if (lpm_ok) begin
				// Fuses pass through as stored, 0 = programmed
				lpm_data <= fuse_byte(cpu_req.z[1:0],
				                      fuses);
			end
		end
	end

endmodule : spf_ctrl

// ===== verification/spf_ctrl_props.sv
// Port checker for the flash self-programming controller.
// Assumes one clock domain; bound into every controller instance.
`timescale 1ns/1ns
module spf_ctrl_props #(
	parameter int FLASH_CYCLES = spf_pkg::FLASH_CYC
) (
	// Clock and reset
	input wire logic                  hclk,
	input wire logic                  hresetn,
	// Register bus
	input wire logic                  hsel,
	input wire logic [31:0]           haddr,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic                  hready,
	input wire logic [31:0]           hrdata,
	// CPU side and status
	input wire spf_pkg::spf_cpu_req_t cpu_req,
	input wire logic                  cpu_stall,
	input wire logic                  lpm_valid,
	input wire logic                  eeprom_write_busy,
	// Flash array
	input wire logic                  flash_erase,
	input wire logic                  flash_program,
	input wire logic [8:0]            flash_page
);
	logic       rd_dp_ff;
	logic       op;
	logic [8:0] z_page;
	int         op_cnt_ff;

	// ======
	// Helpers
	assign op     = flash_erase | flash_program;
	assign z_page = cpu_req.z[15:7];

	// Marks the data phase of a control register read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rd_dp_ff <= 1'b0;
		else
			rd_dp_ff <= hsel & htrans[1] & hready & !hwrite
				& (haddr == spf_pkg::CTRL_OFFSET);
	end

	// Length of the running flash operation
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			op_cnt_ff <= 0;
		else if (op)
			op_cnt_ff <= op_cnt_ff + 1;
		else
			op_cnt_ff <= 0;
	end

	// ======
	// Properties
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_stall_op: assert property (op |-> cpu_stall)
		else $error("cpu runs in flash op");
	a_op_steady: assert property ($rose(op) |-> (op && cpu_stall)[*8])
		else $error("flash op cut short");
	a_op_length: assert property ($fell(op) |-> op_cnt_ff == FLASH_CYCLES)
		else $error("flash op length wrong");
	a_busy_flag: assert property (rd_dp_ff && op |-> hrdata[0])
		else $error("enable low while busy");
	a_top_zero: assert property (rd_dp_ff |-> hrdata[31:6] == 26'h0)
		else $error("bits 7 and 6 not zero");
	a_lpm_cause: assert property (lpm_valid |->
			$past(cpu_req.lpm) && !$past(eeprom_write_busy))
		else $error("load answer not allowed");
	a_read_once: assert property (lpm_valid |=> !lpm_valid)
		else $error("read select survived");
	a_erase_start: assert property ($rose(flash_erase) |->
			$past(cpu_req.spm) && $past(cpu_stall))
		else $error("erase without store");
	a_write_start: assert property ($rose(flash_program) |->
			$past(cpu_req.spm) && $past(cpu_stall))
		else $error("write without store");
	a_page_addr: assert property ($rose(op) |->
			flash_page == $past(z_page))
		else $error("page not from pointer");
	a_stall_cause: assert property ($rose(cpu_stall) |->
			cpu_req.spm && !eeprom_write_busy)
		else $error("stall not allowed");
endmodule : spf_ctrl_props

bind spf_ctrl spf_ctrl_props #(.FLASH_CYCLES(FLASH_CYCLES)) i_spf_ctrl_props (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.cpu_req(cpu_req), .cpu_stall(cpu_stall), .lpm_valid(lpm_valid),
	.eeprom_write_busy(eeprom_write_busy), .flash_erase(flash_erase),
	.flash_program(flash_program), .flash_page(flash_page)
);

// ===== verification/spf_cpu_model.sv
// Behavioural CPU core issuing store and load program-memory instructions.
// Assumes the bench calls run right after a rising edge.
`timescale 1ns/1ns
module spf_cpu_model (
	// Clock
	input  wire logic             hclk,
	// Controller answers
	input  wire logic             lpm_valid,
	input  wire logic [7:0]       lpm_data,
	// Instruction request
	output spf_pkg::spf_cpu_req_t cpu_req
);
	logic       got;
	logic [7:0] got_data;

	// Idle core at time zero
	initial {cpu_req, got, got_data} = '0;

	// Load answer taken at the edge that shows valid
	always @(posedge hclk) begin
		if (lpm_valid === 1'b1) begin
			got <= 1'b1;
			got_data <= lpm_data;
		end
	end

	// One instruction, one cycle long, after dly idle cycles
	task automatic run(input logic spm, input logic lpm, input logic [15:0] z,
			input logic [15:0] d, input int dly);
		got = 1'b0;
		repeat (dly) @(posedge hclk);
		cpu_req <= '{spm, lpm, z, d};
		@(posedge hclk);
		{cpu_req.spm, cpu_req.lpm} <= 2'b00;
		// Released pair shows junk, not the last value
		cpu_req.data_word_pair <= ~d;
	endtask : run
endmodule : spf_cpu_model

// ===== verification/spf_ctrl_tb.sv
// Self-checking bench for the flash self-programming controller.
// Assumes the CPU model and the bound checker; short flash timing.
`timescale 1ns/1ns
module spf_ctrl_tb;
	localparam int FC = 20;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        cpu_stall, lpm_valid, eeprom_write_busy;
	logic        flash_erase, flash_program;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  lpm_data, osc, tso, tsg;
	logic [8:0]  flash_page;
	logic [5:0]  flash_rd_idx;
	logic [15:0] flash_rd_word;
	wire logic   hready;
	int          err_total, num_checks, op_er, op_pg;
	spf_pkg::spf_cpu_req_t cpu_req;
	spf_pkg::spf_fuse_t    fuses;

	assign hready = hreadyout;

	// ======
	// Instances
	spf_ctrl #(.FLASH_CYCLES(FC)) i_spf_ctrl (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .cpu_req(cpu_req), .cpu_stall(cpu_stall),
		.lpm_valid(lpm_valid), .lpm_data(lpm_data),
		.eeprom_write_busy(eeprom_write_busy), .fuses(fuses),
		.osc_cal_byte(osc), .temp_sensor_offset(tso),
		.temp_sensor_gain(tsg), .flash_erase(flash_erase),
		.flash_program(flash_program), .flash_page(flash_page),
		.flash_rd_idx(flash_rd_idx), .flash_rd_word(flash_rd_word));
	spf_cpu_model i_spf_cpu_model (.hclk(hclk), .lpm_valid(lpm_valid),
		.lpm_data(lpm_data), .cpu_req(cpu_req));

	// ======
	// Clock, op counters and watchdog
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (flash_erase === 1'b1) op_er++;
		if (flash_program === 1'b1) op_pg++;
	end
	initial begin
		#2000000;
		err_total++;
		end_of_test();
	end

	// ======
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] seen,
			input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, want, seen);
		end
	endtask : chk

	// Single word transfer; ready and read data taken at rising edges
	task automatic ahb(input logic wr, input logic [31:0] a,
			input logic [31:0] w, output logic [31:0] r);
		{hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'b10, a, wr, 3'b010};
		do @(posedge hclk); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, w};
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask : ahb

	task automatic cmd(input logic [7:0] c);
		logic [31:0] r;
		ahb(1'b1, spf_pkg::CTRL_OFFSET, 32'(c), r);
	endtask : cmd

	task automatic rd_ctrl(output logic [31:0] r);
		ahb(1'b0, spf_pkg::CTRL_OFFSET, '0, r);
	endtask : rd_ctrl

	task automatic bufrd(input logic [5:0] idx, output logic [15:0] w);
		flash_rd_idx <= idx;
		@(negedge hclk) w = flash_rd_word;
		@(posedge hclk);
	endtask : bufrd

	// Waits for the load answer, leaves on a rising edge
	task automatic answer(input string nm, input logic g, input logic [7:0] d);
		repeat (2) @(negedge hclk);
		chk(nm, i_spf_cpu_model.got, g);
		if (g)
			chk(nm, i_spf_cpu_model.got_data, d);
		@(posedge hclk);
	endtask : answer

	// ======
	// Scenarios
	task automatic t_regs();
		logic [31:0] r;
		logic [7:0]  bad [5];
		bad = '{8'h07, 8'h3F, 8'h20, 8'h10, 8'h13};
		rd_ctrl(r);
		chk("ctrl reset", r, 32'(spf_pkg::CTRL_RESET));
		ahb(1'b0, 32'h0000_0010, '0, r);
		chk("unmapped", r, 32'h0);
		foreach (bad[i]) begin
			cmd(bad[i]);
			rd_ctrl(r);
			chk("bad pattern", r, 32'h0);
		end
		cmd(8'hC1);
		rd_ctrl(r);
		chk("bits 7 and 6", r, 32'(spf_pkg::CMD_LOAD));
		repeat (3) @(posedge hclk);
		rd_ctrl(r);
		chk("enable expiry", r, 32'h0);
	endtask : t_regs

	task automatic t_fuse();
		logic [7:0] want [4];
		want[0] = fuses.fuse_low_byte;
		want[1] = {spf_pkg::LOCK_UNUSED, fuses.lock_bit_high, fuses.lock_bit_low};
		want[2] = {spf_pkg::EXT_UNUSED, fuses.fuse_extended_byte};
		want[3] = fuses.fuse_high_byte;
		for (int z = 0; z < 4; z++) begin
			cmd(8'(spf_pkg::CMD_FLR));
			// Pointer 2 loads at the last allowed cycle
			i_spf_cpu_model.run(1'b0, 1'b1, 16'(z), 16'h0, (z == 2) ? 2 : 0);
			answer("fuse byte", 1'b1, want[z]);
		end
	endtask : t_fuse

	task automatic t_sig();
		logic [7:0]  want [7];
		logic [15:0] w;
		want = '{spf_pkg::SIG_ID0, osc, spf_pkg::SIG_ID1, tso,
			spf_pkg::SIG_ID2, tsg, spf_pkg::SIG_RSVD};
		for (int z = 0; z < 7; z++) begin
			cmd(8'(spf_pkg::CMD_SIG));
			// A store first must neither act nor end the window
			i_spf_cpu_model.run(1'b1, 1'b0, 16'(z), 16'h1234, 0);
			i_spf_cpu_model.run(1'b0, 1'b1, 16'(z), 16'h0, 0);
			answer("sig byte", 1'b1, want[z]);
		end
		bufrd(6'h00, w);
		chk("sig store", w, spf_pkg::ERASED_WORD);
	endtask : t_sig

	task automatic t_expire();
		logic [31:0] r;
		logic [7:0]  rc [2];
		rc = '{8'(spf_pkg::CMD_SIG), 8'(spf_pkg::CMD_FLR)};
		foreach (rc[i]) begin
			cmd(rc[i]);
			i_spf_cpu_model.run(1'b0, 1'b1, 16'h0001, 16'h0, 3);
			answer("late load", 1'b0, 8'h00);
			rd_ctrl(r);
			chk("read expiry", r, 32'h0);
		end
		// EEPROM write starts after arming, then covers a control write
		cmd(8'(spf_pkg::CMD_FLR));
		eeprom_write_busy <= 1'b1;
		i_spf_cpu_model.run(1'b0, 1'b1, 16'h0, 16'h0, 0);
		answer("busy load", 1'b0, 8'h00);
		cmd(8'(spf_pkg::CMD_FLR));
		rd_ctrl(r);
		chk("busy write", r, 32'h0);
		eeprom_write_busy <= 1'b0;
		@(posedge hclk);
	endtask : t_expire

	task automatic t_buffer();
		logic [15:0] w;
		logic [31:0] r;
		cmd(8'(spf_pkg::CMD_LOAD));
		i_spf_cpu_model.run(1'b1, 1'b0, 16'h000B, 16'hA5C3, 0);
		rd_ctrl(r);
		chk("store done", r, 32'h0);
		bufrd(6'h05, w);
		chk("store word", w, 16'hA5C3);
		cmd(8'(spf_pkg::CMD_LOAD));
		i_spf_cpu_model.run(1'b1, 1'b0, 16'h007E, 16'h3C5A, 3);
		bufrd(6'h3F, w);
		chk("last cycle", w, 16'h3C5A);
		cmd(8'(spf_pkg::CMD_LOAD));
		eeprom_write_busy <= 1'b1;
		i_spf_cpu_model.run(1'b1, 1'b0, 16'h000E, 16'h1111, 0);
		eeprom_write_busy <= 1'b0;
		bufrd(6'h07, w);
		chk("busy store", w, spf_pkg::ERASED_WORD);
		cmd(8'(spf_pkg::CMD_CLEAR_PAGE_BUFFER));
		bufrd(6'h05, w);
		chk("cleared", w, spf_pkg::ERASED_WORD);
	endtask : t_buffer

	// Store after dly idle cycles; four or more misses the window
	task automatic t_flash(input logic [5:0] c, input int dly);
		logic [31:0] r;
		int          n;
		op_er = 0;
		op_pg = 0;
		cmd(8'(c));
		i_spf_cpu_model.run(1'b1, 1'b0, 16'hD280, 16'h0, dly);
		rd_ctrl(r);
		@(negedge hclk);
		if (dly < 4) begin
			chk("busy ctrl", r, 32'(c));
			chk("page", flash_page, 9'h1A5);
			chk("stall", cpu_stall, 1'b1);
		end
		for (n = 0; n < 100 && cpu_stall !== 1'b0; n++) @(negedge hclk);
		@(posedge hclk);
		rd_ctrl(r);
		chk("ctrl after", r, 32'h0);
		n = (dly < 4) ? FC : 0;
		chk("erase time", op_er, (c == spf_pkg::CMD_PGE) ? n : 0);
		chk("write time", op_pg, (c == spf_pkg::CMD_PGW) ? n : 0);
	endtask : t_flash

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	// ======
	// Main sequence
	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
		eeprom_write_busy = 1'b0;
		fuses = '{8'h62, 8'hDF, 1'b0, 1'b1, 1'b0};
		{osc, tso, tsg} = 24'h9C_47B3;
		flash_rd_idx = 6'h00;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_fuse();
		t_sig();
		t_expire();
		t_buffer();
		t_flash(spf_pkg::CMD_PGE, 0);
		t_flash(spf_pkg::CMD_PGW, 3);
		t_flash(spf_pkg::CMD_PGE, 4);
		t_flash(spf_pkg::CMD_PGW, 4);
		end_of_test();
	end
endmodule : spf_ctrl_tb
